// *** bench/dpm_chk.sv ***
/* port checker for the power mode sequencer.
 * bound to dpm_sequencer; sim uses a short enable count. */
`timescale 1ns/100ps
module dpm_chk (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic chip_select_low_in,
	input wire logic logic_supply_low_in,
	input wire logic power_stage_fault_in,
	input wire logic serial_out_out,
	input wire logic serial_out_oe_out,
	input wire logic drivers_enable_out,
	input wire logic outputs_hiz_out,
	input wire logic inputs_hiz_out,
	input wire logic active_mode_out,
	input wire logic [23:0] input_reg0_out,
	input wire logic [7:0] status0_out,
	input wire logic [7:0] status1_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// ============
	// link side; six cycles cover sync and edge detect
	quiet_out_a: assert property (chip_select_low_in[*6]
		|-> !serial_out_oe_out) else $error("out driven, no select");
	select_drive_a: assert property (
		(!chip_select_low_in && !logic_supply_low_in)[*6]
		|-> serial_out_oe_out) else $error("out not driven");
	fault_bit_a: assert property ($fell(chip_select_low_in)
		|-> ##4 serial_out_out == (|{status0_out, status1_out}))
		else $error("fault bit wrong");
	// ============
	// modes
	standby_hiz_a: assert property ((!input_reg0_out[23])[*2]
		|-> inputs_hiz_out && !drivers_enable_out) else $error("standby");
	wake_a: assert property ($rose(input_reg0_out[23])
		|-> ##[0:40] active_mode_out) else $error("no wake");
	enable_time_a: assert property (
		disable iff (!arst_n_in || power_stage_fault_in)
		$rose(input_reg0_out[23])
		|-> (!drivers_enable_out)[*8] ##[1:40] drivers_enable_out)
		else $error("enable delay");
	por_clear_a: assert property (logic_supply_low_in[*5]
		|-> outputs_hiz_out && status0_out == 8'h00
		&& status1_out == 8'h00) else $error("supply loss");
	keep_reg_a: assert property (
		(chip_select_low_in && !logic_supply_low_in)[*8]
		|=> $stable(input_reg0_out)) else $error("reg0 changed");
endmodule
bind dpm_sequencer dpm_chk i_chk (.ref_clk_in, .arst_n_in,
	.chip_select_low_in, .logic_supply_low_in, .power_stage_fault_in,
	.serial_out_out, .serial_out_oe_out, .drivers_enable_out,
	.outputs_hiz_out, .inputs_hiz_out, .active_mode_out,
	.input_reg0_out, .status0_out, .status1_out);

// *** bench/dpm_host.sv ***
/* host model of the serial control link, mode 0, lsb first.
 * assumes the bench gives it serial out while enabled, its inverse otherwise. */
`timescale 1ns/100ps
module dpm_host (
	input wire logic miso_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic mosi_out
);
	logic [23:0] rx_bits;
	initial begin
		cs_n_out = 1'h1;
		sclk_out = 1'h0;
		mosi_out = 1'h0;
	end
	// n other than 24 sends a frame the device must drop
	task automatic xfer(input logic [23:0] d, input int n, input int gap);
		cs_n_out = 1'h0;
		#400;
		for (int i = 0; i < n; i++) begin
			mosi_out = d[i];
			#160 sclk_out = 1'h1;
			rx_bits[i] = miso_in;
			#160 sclk_out = 1'h0;
		end
		#400 mosi_out = 1'h0;
		cs_n_out = 1'h1;
		#(gap * 1000);
	endtask
endmodule

// *** bench/dpm_sequencer_bench.sv ***
/* bench for the power mode sequencer: frame table, then hand cases.
 * host model drives the link; enable count cut to 20 cycles. */
`timescale 1ns/100ps
module dpm_sequencer_bench;
	typedef struct packed {
		logic [23:0] d;
		int gap;
		logic [23:0] r;
		logic a;
	} dpm_row_type;
	logic clk = 1'h0, rst_n = 1'h0, cs_n, sclk, mosi, so, oe;
	logic vlow = 1'h0, pf = 1'h0, drv, ohiz, ihiz, act;
	logic [7:0] ev0 = 8'h00, ev1 = 8'h00, st0, st1;
	logic [23:0] reg0;
	int err_count = 0, n_tests = 0, cyc = 0;
	dpm_row_type rows [4] = '{'{24'h80_0001, 20, 24'h80_0001, 1'h1},
		'{24'hC0_00F0, 4, 24'hC0_00F0, 1'h1},
		'{24'h00_5555, 4, 24'h00_0000, 1'h0},
		'{24'h80_A5A5, 20, 24'h80_A5A5, 1'h1}};
	always #20 clk = ~clk;
	dpm_sequencer #(.ENABLE_CYCLES(13'h0014)) i_dut (.ref_clk_in(clk),
		.arst_n_in(rst_n), .chip_select_low_in(cs_n), .serial_clk_in(sclk),
		.serial_in_line_in(mosi), .logic_supply_low_in(vlow),
		.power_stage_fault_in(pf), .status0_event_in(ev0),
		.status1_event_in(ev1), .serial_out_out(so), .serial_out_oe_out(oe),
		.drivers_enable_out(drv), .outputs_hiz_out(ohiz),
		.inputs_hiz_out(ihiz), .active_mode_out(act),
		.input_reg0_out(reg0), .status0_out(st0), .status1_out(st1));
	dpm_host i_host (.miso_in(oe ? so : ~so), .cs_n_out(cs_n),
		.sclk_out(sclk), .mosi_out(mosi));
	task chk(input string nm, input logic [23:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s exp %h got %h", nm, exp, got);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// hang guard, well above the whole run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		tick(5);
		chk("rst", 24'({ohiz, ihiz, oe}), 24'h00_0006);
		chk("rst0", reg0, 24'h00_0000);
		rst_n = 1'h1;
		tick(1);
		chk("rst_oe", 24'(oe), 24'h00_0000);
		tick(2);
		$display("test reset done");
		foreach (rows[i]) begin
			i_host.xfer(rows[i].d, 24, rows[i].gap);
			chk("reg0", reg0, rows[i].r);
			chk("act", 24'({act, ihiz}), 24'({rows[i].a, ~rows[i].a}));
			chk("drv", 24'({drv, ohiz}), 24'({rows[i].a, ~rows[i].a}));
		end
		$display("test table done");
		i_host.xfer(24'h00_0000, 23, 4);
		chk("short", reg0, 24'h80_A5A5);
		ev0 = 8'h05;
		ev1 = 8'h80;
		tick(1);
		ev0 = 8'h00;
		ev1 = 8'h00;
		pf = 1'h1;
		tick(10);
		chk("gate", 24'({drv, ohiz}), 24'h00_0001);
		pf = 1'h0;
		tick(10);
		chk("glitch", reg0, 24'h80_A5A5);
		chk("keep_st", 24'({st1, st0}), 24'h00_8005);
		$display("test glitch done");
		i_host.xfer(24'h80_0000, 17, 4);
		chk("rx", 24'(i_host.rx_bits[16:0]), 24'h01_000B);
		$display("test readout done");
		vlow = 1'h1;
		tick(10);
		chk("por", {st0, st1, 6'(act), ohiz, oe}, 24'h00_0002);
		chk("por0", reg0, 24'h00_0000);
		vlow = 1'h0;
		tick(10);
		i_host.xfer(24'h80_0001, 24, 20);
		chk("rewake", 24'({act, drv}), 24'h00_0003);
		$display("test supply done");
		end_sim;
	end
endmodule

// *** verilog/dpm_pkg.sv ***
/*
 * shared constants and carrier types for the driver power mode sequencer.
 * assumes a 25 MHz core clock; the serial link is sampled, not clocked.
 */
package dpm_pkg;

	// ===========================================================
	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int STANDBY_BIT = 23;
	localparam int STATUS_BITS = 8;
	localparam logic [4:0] FRAME_DONE = 5'h18;
	localparam logic [23:0] FRAME_RESET = 24'h00_0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [6:0] TX_PAD = 7'h00;
	// synchroniser reset: select idles high so reset leaves no false edge
	localparam logic [4:0] PINS_RESET = 5'h10;

	// ===========================================================
	// timing
	localparam int CLK_KHZ = 25000;
	localparam int T_SET_TYP_US = 160;
	localparam int T_SET_MAX_US = 300;
	// longest time rounds down
	localparam int SET_MAX_INT = (T_SET_MAX_US * CLK_KHZ) / 1000;
	localparam int SET_DEF_INT = (T_SET_TYP_US * CLK_KHZ) / 1000;
	localparam logic [12:0] SET_MAX_CYCLES = SET_MAX_INT[12:0];
	localparam logic [12:0] SET_DEF_CYCLES = SET_DEF_INT[12:0];
	localparam logic [12:0] CNT_ONE = 13'h0001;
	localparam logic [12:0] CNT_ZERO = 13'h0000;
	localparam logic [4:0] BIT_ONE = 5'h01;
	localparam logic [4:0] BIT_ZERO = 5'h00;

	// ===========================================================
	// types
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b00,
		MODE_WAKE = 2'b01,
		MODE_ACTIVE = 2'b10
	} dpm_mode_type;

	typedef struct packed {
		logic chip_select_low;
		logic sclk;
		logic serial_in_line;
		logic supply_low;
		logic stage_fault;
	} dpm_pins_type;

endpackage

// *** verilog/dpm_sequencer.sv ***
/*
 * power mode sequencer of a serially controlled actuator driver:
 * standby entry and exit, supply power-on reset, serial frame capture
 * and the fault/status serial output.
 * assumes pins arrive asynchronously and the host keeps link timing.
 */
`timescale 1ns/100ps

// Contract
// - writing bit 23 zero enters standby
// - standby clears latched data, inputs/outputs high-z
// - writing bit 23 one leaves standby
// - drivers enabled within 300 us of wake
// - logic supply rising initialises all state (por leaves tx_r and serial_out_out as they were)
// - logic supply loss: outputs high-z, status cleared
// - power-stage supply glitches keep control/status
// - serial output high-z while select high
// - sample rising clock edge, change on falling
// - frames shift least significant bit first
// - select low shows global fault immediately
module dpm_sequencer #(
	parameter logic [12:0] ENABLE_CYCLES = dpm_pkg::SET_DEF_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic chip_select_low_in,
	input wire logic serial_clk_in,
	input wire logic serial_in_line_in,
	input wire logic logic_supply_low_in,
	input wire logic power_stage_fault_in,
	input wire logic [7:0] status0_event_in,
	input wire logic [7:0] status1_event_in,
	output logic serial_out_out,
	output logic serial_out_oe_out,
	output logic drivers_enable_out,
	output logic outputs_hiz_out,
	output logic inputs_hiz_out,
	output logic active_mode_out,
	output logic [23:0] input_reg0_out,
	output logic [7:0] status0_out,
	output logic [7:0] status1_out
);
	dpm_pkg::dpm_pins_type pins_w;
	dpm_pkg::dpm_mode_type mode_r;
	logic sclk_d_r;
	logic cs_d_r;
	logic [23:0] rx_r;
	logic [4:0] bit_cnt_r;
	logic [23:0] tx_r;
	logic [12:0] wake_cnt_r;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic frame_load;
	logic fault;
	logic por;

	// ===========================================================
	// pin synchronisation
	dpm_sync #(.WIDTH(5),
		.RST_VAL(dpm_pkg::PINS_RESET)) u_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.d_in({chip_select_low_in, serial_clk_in, serial_in_line_in,
			logic_supply_low_in, power_stage_fault_in}),
		.q_out(pins_w)
	);

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sclk_d_r <= pins_w.sclk;
			cs_d_r <= pins_w.chip_select_low;
		end
	end

	assign por = pins_w.supply_low;
	assign sclk_rise = pins_w.sclk & ~sclk_d_r;
	assign sclk_fall = ~pins_w.sclk & sclk_d_r;
	assign cs_fall = ~pins_w.chip_select_low & cs_d_r;
	assign cs_rise = pins_w.chip_select_low & ~cs_d_r;
	// short or long frames are dropped, not half-applied
	assign frame_load = cs_rise & (bit_cnt_r == dpm_pkg::FRAME_DONE);
	assign fault = |{status0_out, status1_out};

	// ===========================================================
	// frame receive
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_r <= dpm_pkg::FRAME_RESET;
			bit_cnt_r <= dpm_pkg::BIT_ZERO;
		end else if (por) begin
			rx_r <= dpm_pkg::FRAME_RESET;
			bit_cnt_r <= dpm_pkg::BIT_ZERO;
		end else if (cs_fall) begin
			bit_cnt_r <= dpm_pkg::BIT_ZERO;
		end else if (!pins_w.chip_select_low && sclk_rise) begin
			// first bit lands in bit 0 after the full frame
			rx_r <= {pins_w.serial_in_line, rx_r[23:1]};
			if (bit_cnt_r != 5'h1f) begin
				bit_cnt_r <= bit_cnt_r + dpm_pkg::BIT_ONE;
			end
		end
	end

	// ===========================================================
	// input register and mode
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			input_reg0_out <= dpm_pkg::FRAME_RESET;
		end else if (por) begin
			input_reg0_out <= dpm_pkg::FRAME_RESET;
		end else if (frame_load) begin
			if (rx_r[dpm_pkg::STANDBY_BIT]) begin
				input_reg0_out <= rx_r;
			end else begin
				input_reg0_out <= dpm_pkg::FRAME_RESET;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_r <= dpm_pkg::MODE_STANDBY;
			wake_cnt_r <= dpm_pkg::CNT_ZERO;
		end else if (por) begin
			mode_r <= dpm_pkg::MODE_STANDBY;
			wake_cnt_r <= dpm_pkg::CNT_ZERO;
		end else if (frame_load && !rx_r[dpm_pkg::STANDBY_BIT]) begin
			mode_r <= dpm_pkg::MODE_STANDBY;
			wake_cnt_r <= dpm_pkg::CNT_ZERO;
		end else begin
			unique case (mode_r)
				dpm_pkg::MODE_STANDBY: begin
					if (frame_load) begin
						mode_r <= dpm_pkg::MODE_WAKE;
					end
					wake_cnt_r <= dpm_pkg::CNT_ZERO;
				end
				dpm_pkg::MODE_WAKE: begin
					// the host is expected to stay quiet meanwhile
					if (wake_cnt_r >= ENABLE_CYCLES - dpm_pkg::CNT_ONE) begin
						mode_r <= dpm_pkg::MODE_ACTIVE;
					end else begin
						wake_cnt_r <= wake_cnt_r + dpm_pkg::CNT_ONE;
					end
				end
				dpm_pkg::MODE_ACTIVE: begin
					wake_cnt_r <= dpm_pkg::CNT_ZERO;
				end
				default: begin
					mode_r <= dpm_pkg::MODE_STANDBY;
					wake_cnt_r <= dpm_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	// ===========================================================
	// power stage control
	// stage faults only gate drivers; nothing latched is touched
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			drivers_enable_out <= 1'b0;
			outputs_hiz_out <= 1'b1;
			inputs_hiz_out <= 1'b1;
			active_mode_out <= 1'b0;
		end else begin
			drivers_enable_out <= (mode_r == dpm_pkg::MODE_ACTIVE) &&
				!por && !pins_w.stage_fault;
			outputs_hiz_out <= (mode_r != dpm_pkg::MODE_ACTIVE) ||
				por || pins_w.stage_fault;
			inputs_hiz_out <= (mode_r == dpm_pkg::MODE_STANDBY) || por;
			active_mode_out <= (mode_r == dpm_pkg::MODE_ACTIVE) && !por;
		end
	end

	// ===========================================================
	// status latches
	// supply loss and standby clear outrank new events by design
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			status0_out <= dpm_pkg::STATUS_RESET;
			status1_out <= dpm_pkg::STATUS_RESET;
		end else if (por || mode_r == dpm_pkg::MODE_STANDBY) begin
			status0_out <= dpm_pkg::STATUS_RESET;
			status1_out <= dpm_pkg::STATUS_RESET;
		end else begin
			status0_out <= status0_out | status0_event_in;
			status1_out <= status1_out | status1_event_in;
		end
	end

	// ===========================================================
	// serial output
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_r <= dpm_pkg::FRAME_RESET;
			serial_out_out <= 1'b0;
			serial_out_oe_out <= 1'b0;
		end else begin
			serial_out_oe_out <= !pins_w.chip_select_low && !por;
			if (cs_fall) begin
				tx_r <= {dpm_pkg::TX_PAD, status1_out, status0_out, fault};
				serial_out_out <= fault;
			end else if (!pins_w.chip_select_low && sclk_fall) begin
				tx_r <= {1'b0, tx_r[23:1]};
				serial_out_out <= tx_r[1];
			end else if (!pins_w.chip_select_low && !sclk_d_r &&
				bit_cnt_r == dpm_pkg::BIT_ZERO) begin
				serial_out_out <= fault;
			end
		end
	end
endmodule

// *** verilog/dpm_sync.sv ***
/*
 * two-flop synchroniser, one per bit.
 * assumes the inputs are asynchronous levels; only stage two is read.
 */
`timescale 1ns/100ps
module dpm_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_r;

	// ===========================================================
	// per-bit stages
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					// reset to the pin's idle level, not blindly to zero
					meta_r[i] <= RST_VAL[i];
					q_out[i] <= RST_VAL[i];
				end else begin
					meta_r[i] <= d_in[i];
					q_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule
